// file: hw/sdas_seq.sv
// Sequencer of the delta-sigma converter: modes, triggers, priming, results.
// Assumes synchronous inputs, one 25 MHz clock and a strobe register port.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Four modes: single, multi, continuous and turbo multi sample.
// - A run starts on software start bit or hardware start input.
// - Completion sets status flag and done output, held until result read.
// - Single mode idles in standby until a start event.
// - Single trigger runs four conversions; first three only prime.
// - Single result valid after fourth conversion, done raised then.
// - After result read, single mode returns to standby.
// - Continuous first result only after three priming conversions.
// - Continuous delivers one result per conversion period without triggers.
// - Output uses last four samples; invalid until fourth after input change.
// - Decimator turns single-bit stream into parallel result words.
// - 12-bit setting plus faster lower-resolution setting.
// - Completion visible by status polling or by the done output.
// - Multi mode re-primes between samples and restarts automatically.
module sdas_seq (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input sdas_pkg::sdas_bus_req_t bus_i,
    output logic [sdas_pkg::DW-1:0] rdata_o,
    input wire logic mod_bit_i,
    input wire logic soc_i,
    output logic eoc_o,
    output logic busy_o,
    output logic [sdas_pkg::MUXW-1:0] mux_sel_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HOLD
    } sdas_run_t;

    typedef struct packed {
        sdas_run_t run;
        logic [1:0] mode;
        logic fast;
        logic [sdas_pkg::MUXW-1:0] mux;
        logic [1:0] prime;
        logic primed;
        logic clr;
        logic pend;
        logic [sdas_pkg::RW-1:0] res;
        logic done;
        logic busy;
        logic [3:0] div;
        logic [sdas_pkg::DW-1:0] rdata;
    } sdas_st_t;

    sdas_st_t s_r;
    sdas_st_t s_nxt;
    sdas_pkg::sdas_dec_out_t dec;
    logic mod_en;
    logic dec_en;
    logic eff_fast;
    logic ctrl_wr;
    logic start_evt;
    logic stop_wr;
    logic mux_chg;
    logic res_rd;
    logic push;
    logic pop;
    logic fifo_ready;
    logic fifo_valid;
    logic [sdas_pkg::RW-1:0] fifo_dout;
    logic [sdas_pkg::LVW-1:0] level;

    // Clamp the four-conversion sum to the selected resolution
    function automatic logic [sdas_pkg::RW-1:0] sat(input logic [sdas_pkg::RW-1:0] v,
                                                    input logic fast);
        logic [sdas_pkg::RW-1:0] top;
        top = fast ? sdas_pkg::MAX_LO : sdas_pkg::MAX_HI;
        sat = (v > top) ? top : v;
    endfunction : sat

    assign rdata_o = s_r.rdata;
    assign eoc_o = s_r.done;
    assign busy_o = s_r.busy;
    assign mux_sel_o = s_r.mux;

    // Turbo always runs the short conversion
    assign eff_fast = s_r.fast || (s_r.mode == 2'(sdas_pkg::SDAS_TURBO));
    assign mod_en = (s_r.div == sdas_pkg::MOD_DIV - 4'h1);
    // Decimator stalls while a result waits for FIFO room
    assign dec_en = mod_en && (s_r.run == ST_RUN) && !s_r.pend && !s_r.clr;
    assign push = s_r.pend && fifo_ready;
    assign res_rd = bus_i.rd && (bus_i.addr == sdas_pkg::A_RES);
    assign pop = res_rd && fifo_valid;

    // Bus decode of control writes
    assign ctrl_wr = bus_i.wr && (bus_i.addr == sdas_pkg::A_CTRL);
    assign start_evt = (ctrl_wr && bus_i.wdata[sdas_pkg::B_START]) || soc_i;
    assign stop_wr = ctrl_wr && bus_i.wdata[sdas_pkg::B_STOP];
    assign mux_chg = ctrl_wr
        && (bus_i.wdata[sdas_pkg::B_MUX +: sdas_pkg::MUXW] != s_r.mux);

    sdas_decim u_decim (
        .clk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .en_i(dec_en),
        .bit_i(mod_bit_i),
        .clr_i(s_r.clr),
        .fast_i(eff_fast),
        .out_o(dec)
    );

    sdas_fifo #(
        .W(sdas_pkg::RW),
        .DEPTH(sdas_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(s_r.pend),
        .in_ready_o(fifo_ready),
        .in_data_i(s_r.res),
        .out_valid_o(fifo_valid),
        .out_ready_i(res_rd),
        .out_data_o(fifo_dout),
        .level_o(level)
    );

    // Sequencing, register file and read path
    always_comb begin
        s_nxt = s_r;
        s_nxt.clr = 1'b0;
        s_nxt.rdata = '0;
        s_nxt.div = mod_en ? 4'h0 : s_r.div + 4'h1;
        if (ctrl_wr) begin
            s_nxt.mode = bus_i.wdata[sdas_pkg::B_MODE +: 2];
            s_nxt.fast = bus_i.wdata[sdas_pkg::B_FAST];
            s_nxt.mux = bus_i.wdata[sdas_pkg::B_MUX +: sdas_pkg::MUXW];
        end
        if (push) begin
            s_nxt.pend = 1'b0;
        end
        unique case (s_r.run)
            ST_IDLE: begin
                if (start_evt) begin
                    s_nxt.run = ST_RUN;
                    s_nxt.clr = 1'b1;
                    s_nxt.prime = '0;
                    s_nxt.primed = 1'b0;
                end
            end
            ST_RUN: begin
                // Further start events fall through untouched
                if (dec.pulse && s_r.prime != sdas_pkg::PRIME_LAST) begin
                    s_nxt.prime = s_r.prime + 2'h1;
                end else if (dec.pulse) begin
                    s_nxt.res = sat(dec.sum, eff_fast);
                    s_nxt.pend = 1'b1;
                    s_nxt.primed = 1'b1;
                    unique case (s_r.mode)
                        2'(sdas_pkg::SDAS_SINGLE): begin
                            s_nxt.run = ST_HOLD;
                        end
                        2'(sdas_pkg::SDAS_CONT): begin
                            s_nxt.run = ST_RUN;
                        end
                        default: begin
                            s_nxt.clr = 1'b1;
                            s_nxt.prime = '0;
                        end
                    endcase
                end
            end
            ST_HOLD: begin
                if (!s_r.pend && !s_r.done) begin
                    s_nxt.run = ST_IDLE;
                end
            end
            default: begin
                s_nxt.run = ST_IDLE;
            end
        endcase
        // Input switch poisons the pipeline; re-prime from scratch
        if (mux_chg && s_r.run == ST_RUN) begin
            s_nxt.clr = 1'b1;
            s_nxt.prime = '0;
            s_nxt.primed = 1'b0;
        end
        if (stop_wr) begin
            s_nxt.run = ST_IDLE;
        end
        // A push in the same cycle as the last read keeps the flag set
        s_nxt.done = push || (s_r.done && !(pop && level == sdas_pkg::LVW'(1)));
        s_nxt.busy = (s_nxt.run != ST_IDLE);
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                sdas_pkg::A_CTRL: begin
                    s_nxt.rdata[sdas_pkg::B_MODE +: 2] = s_r.mode;
                    s_nxt.rdata[sdas_pkg::B_FAST] = s_r.fast;
                    s_nxt.rdata[sdas_pkg::B_MUX +: sdas_pkg::MUXW] = s_r.mux;
                end
                sdas_pkg::A_STAT: begin
                    s_nxt.rdata[sdas_pkg::B_DONE] = s_r.done;
                    s_nxt.rdata[sdas_pkg::B_BUSY] = s_r.busy;
                    s_nxt.rdata[sdas_pkg::B_PRIMED] = s_r.primed;
                    s_nxt.rdata[sdas_pkg::B_FULL] = !fifo_ready;
                    s_nxt.rdata[sdas_pkg::B_LVL +: sdas_pkg::LVW] = level;
                end
                sdas_pkg::A_RES: begin
                    s_nxt.rdata[sdas_pkg::RW-1:0] = fifo_dout;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Checks on sequencing
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    done_hold_a: assert property (eoc_o && !pop |=> eoc_o)
        else $error("done output dropped before read");
    done_cause_a: assert property ($rose(eoc_o) |-> $past(push))
        else $error("done rose without a result");
    idle_stay_a: assert property (s_r.run == ST_IDLE && !start_evt |=> !busy_o)
        else $error("left standby without start");
    start_run_a: assert property (s_r.run == ST_IDLE && start_evt && !stop_wr
        |=> busy_o && s_r.clr && s_r.prime == 2'h0)
        else $error("start event not taken");
    prime_step_a: assert property (s_r.run == ST_RUN && dec.pulse && s_r.prime != 2'h3
        && !mux_chg |=> s_r.prime == $past(s_r.prime) + 2'h1 && !$rose(s_r.pend))
        else $error("priming conversion misbehaved");
    start_ignore_a: assert property (s_r.run == ST_RUN && start_evt && !dec.pulse
        && !mux_chg && !stop_wr |=> $stable(s_r.prime) && !s_r.clr)
        else $error("start during run disturbed priming");
    single_back_a: assert property (s_r.run == ST_HOLD && !s_r.pend && !s_r.done
        |=> s_r.run == ST_IDLE)
        else $error("single mode did not return to standby");
    first_primed_a: assert property ($rose(s_r.primed) |-> $past(s_r.prime) == 2'h3)
        else $error("result before three priming conversions");
    cont_keep_a: assert property (s_r.run == ST_RUN && s_r.mode == 2'(sdas_pkg::SDAS_CONT)
        && dec.pulse && !ctrl_wr |=> s_r.run == ST_RUN && !s_r.clr)
        else $error("continuous mode stopped after a result");
    mux_reprime_a: assert property (mux_chg && s_r.run == ST_RUN
        |=> s_r.clr && s_r.prime == 2'h0 && !s_r.primed)
        else $error("input change left output valid");
    multi_reprime_a: assert property (s_r.run == ST_RUN && dec.pulse && s_r.prime == 2'h3
        && s_r.mode == 2'(sdas_pkg::SDAS_MULTI) && !ctrl_wr
        |=> s_r.clr ##1 busy_o)
        else $error("multi mode did not re-prime");
    res_range_a: assert property (s_r.pend |-> s_r.res <= sdas_pkg::MAX_HI)
        else $error("result above 12-bit range");
    stat_done_a: assert property (bus_i.rd && bus_i.addr == sdas_pkg::A_STAT
        |=> rdata_o[0] == $past(eoc_o))
        else $error("status flag disagrees with done output");

    single_done_c: cover property (s_r.run == ST_HOLD ##[1:300] s_r.run == ST_IDLE);
    cont_two_c: cover property (s_r.mode == 2'(sdas_pkg::SDAS_CONT) && push
        ##[1:1000] push);
    multi_again_c: cover property (s_r.mode == 2'(sdas_pkg::SDAS_MULTI) && push);
    start_busy_c: cover property (s_r.run == ST_RUN && start_evt);
endmodule : sdas_seq

// file: hw/sdas_pkg.sv
// Shared constants, register map and carrier types of the ADC sequencer.
// Assumes a single 25 MHz clock; all slower rates are enable pulses.
package sdas_pkg;
    localparam int AW = 4;
    localparam int DW = 32;
    localparam int RW = 13;
    localparam int CW = 11;
    localparam int FIFO_DEPTH = 32;
    localparam int LVW = 6;
    // Register byte addresses
    localparam logic [AW-1:0] A_CTRL = 4'h0;
    localparam logic [AW-1:0] A_STAT = 4'h4;
    localparam logic [AW-1:0] A_RES = 4'h8;
    // Control fields
    localparam int B_START = 0;
    localparam int B_STOP = 1;
    localparam int B_MODE = 2;
    localparam int B_FAST = 4;
    localparam int B_MUX = 8;
    localparam int MUXW = 4;
    // Status fields
    localparam int B_DONE = 0;
    localparam int B_BUSY = 1;
    localparam int B_PRIMED = 2;
    localparam int B_FULL = 3;
    localparam int B_LVL = 8;
    // Modulator bit rate is mclk divided by this
    localparam logic [3:0] MOD_DIV = 4'h2;
    // Oversampling per conversion and result ceilings
    localparam logic [CW-1:0] OSR_HI = 11'h400;
    localparam logic [CW-1:0] OSR_LO = 11'h040;
    localparam logic [RW-1:0] MAX_HI = 13'h0fff;
    localparam logic [RW-1:0] MAX_LO = 13'h00ff;
    localparam logic [1:0] PRIME_LAST = 2'h3;

    typedef enum logic [1:0] {
        SDAS_SINGLE,
        SDAS_MULTI,
        SDAS_CONT,
        SDAS_TURBO
    } sdas_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } sdas_bus_req_t;

    typedef struct packed {
        logic [RW-1:0] sum;
        logic pulse;
    } sdas_dec_out_t;
endpackage : sdas_pkg

// file: hw/sdas_fifo.sv
// Result FIFO with a registered head word and valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module sdas_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [LW-1:0] cnt;
        logic [W-1:0] dout;
    } sdas_fifo_st_t;
    sdas_fifo_st_t s_r;
    sdas_fifo_st_t s_nxt;
    logic push;
    logic pop;
    logic [LW-1:0] left;

    assign in_ready_o = (s_r.cnt != LW'(DEPTH));
    assign out_valid_o = (s_r.cnt != '0);
    assign out_data_o = s_r.dout;
    assign level_o = s_r.cnt;

    // Head word is reloaded every cycle so reads never see a stale slot
    always_comb begin
        s_nxt = s_r;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        left = s_r.cnt - LW'(pop);
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = s_r.wp + PW'(1);
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + PW'(1);
        end
        s_nxt.cnt = left + LW'(push);
        s_nxt.dout = (push && left == '0) ? in_data_i : s_r.mem[s_nxt.rp];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : sdas_fifo

// file: hw/sdas_decim.sv
// Decimator: counts modulator ones per conversion and sums the last four.
// Assumes en_i is a one-cycle modulator sample enable.
`timescale 1ns/1ps
module sdas_decim (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic bit_i,
    input wire logic clr_i,
    input wire logic fast_i,
    output sdas_pkg::sdas_dec_out_t out_o
);
    typedef struct packed {
        logic [sdas_pkg::CW-1:0] cnt;
        logic [sdas_pkg::CW-1:0] acc;
        logic [3:0][sdas_pkg::CW-1:0] hist;
        logic [sdas_pkg::RW-1:0] sum;
        logic pulse;
    } sdas_dec_st_t;
    sdas_dec_st_t s_r;
    sdas_dec_st_t s_nxt;
    logic [sdas_pkg::CW-1:0] osr;
    logic [sdas_pkg::CW-1:0] acc_inc;

    assign out_o = '{sum: s_r.sum, pulse: s_r.pulse};

    // One conversion per osr samples; output spans the four latest
    always_comb begin
        s_nxt = s_r;
        s_nxt.pulse = 1'b0;
        osr = fast_i ? sdas_pkg::OSR_LO : sdas_pkg::OSR_HI;
        acc_inc = s_r.acc + sdas_pkg::CW'(bit_i);
        if (clr_i) begin
            s_nxt.cnt = '0;
            s_nxt.acc = '0;
            s_nxt.hist = '0;
        end else if (en_i) begin
            if (s_r.cnt == osr - sdas_pkg::CW'(1)) begin
                s_nxt.hist = {s_r.hist[2:0], acc_inc};
                s_nxt.sum = sdas_pkg::RW'(s_nxt.hist[0]) + sdas_pkg::RW'(s_nxt.hist[1])
                    + sdas_pkg::RW'(s_nxt.hist[2]) + sdas_pkg::RW'(s_nxt.hist[3]);
                s_nxt.pulse = 1'b1;
                s_nxt.cnt = '0;
                s_nxt.acc = '0;
            end else begin
                s_nxt.cnt = s_r.cnt + sdas_pkg::CW'(1);
                s_nxt.acc = acc_inc;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : sdas_decim

// file: dv/sdas_host_model.sv
// Host side model: a DMA-like reader that drains results on the done output.
// Assumes the strobe register port with read data one cycle after the strobe.
`timescale 1ns/1ps
module sdas_host_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic [7:0] stall_i,
    input wire logic eoc_i,
    input wire logic [sdas_pkg::DW-1:0] rdata_i,
    output sdas_pkg::sdas_bus_req_t req_o,
    output logic [15:0] cnt_o,
    output logic [sdas_pkg::DW-1:0] data_o,
    output logic [31:0] stamp_o
);
    logic [31:0] cyc_r;
    logic [7:0] wait_r;
    logic [1:0] st_r;

    // Stall lets the bench make the reader slow; en only gates a new read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_o <= '0;
            cnt_o <= 16'h0;
            data_o <= '0;
            stamp_o <= 32'h0;
            cyc_r <= 32'h0;
            wait_r <= 8'h0;
            st_r <= 2'h0;
        end else begin
            cyc_r <= cyc_r + 32'h1;
            req_o.rd <= 1'b0;
            case (st_r)
                2'h0: if (en_i && eoc_i) begin
                    wait_r <= stall_i;
                    st_r <= 2'h1;
                end
                2'h1: if (wait_r == 8'h0) begin
                    req_o.rd <= 1'b1;
                    req_o.addr <= sdas_pkg::A_RES;
                    st_r <= 2'h2;
                end else begin
                    wait_r <= wait_r - 8'h1;
                end
                2'h2: st_r <= 2'h3;
                default: begin
                    data_o <= rdata_i;
                    cnt_o <= cnt_o + 16'h1;
                    stamp_o <= cyc_r;
                    st_r <= 2'h0;
                end
            endcase
        end
    end
endmodule : sdas_host_model

// file: dv/sdas_seq_tb_top.sv
// Bench for the ADC sequencer: result table, timing, re-priming and FIFO.
// Assumes the host model drains results whenever host_en is high.
`timescale 1ns/1ps
module sdas_seq_tb_top;
    typedef struct packed {
        logic [1:0] mode;
        logic fast;
        logic hw;
        logic [1:0] pat;
        logic [12:0] exp;
    } sdas_row_t;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    sdas_pkg::sdas_bus_req_t tb_req = '0;
    sdas_pkg::sdas_bus_req_t host_req;
    sdas_pkg::sdas_bus_req_t bus_i;
    logic [31:0] rdata_o;
    logic mod_bit_i = 1'b0;
    logic soc_i = 1'b0;
    logic eoc_o;
    logic busy_o;
    logic [3:0] mux_sel_o;
    logic host_en = 1'b0;
    logic [7:0] stall = 8'h00;
    logic [1:0] pat = 2'h0;
    logic [2:0] ph = 3'h0;
    logic [15:0] hcnt;
    logic [31:0] hdata;
    logic [31:0] hstamp;
    int error_cnt = 0;
    int checked = 0;
    sdas_row_t rows [8];

    initial forever #20 mclk_i = ~mclk_i;

    // Half density toggles every 4 clocks, so any 64 samples hold 32 ones
    always @(posedge mclk_i) begin
        ph <= ph + 3'h1;
        mod_bit_i <= (pat == 2'h1) | ((pat == 2'h2) & ph[2]);
    end

    assign bus_i = host_req.rd ? host_req : tb_req;

    sdas_seq u_sdas_seq (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .mod_bit_i(mod_bit_i), .soc_i(soc_i), .eoc_o(eoc_o),
        .busy_o(busy_o), .mux_sel_o(mux_sel_o));
    sdas_host_model u_sdas_host_model (.clk_i(mclk_i), .arst_n_i(arst_n_i), .en_i(host_en),
        .stall_i(stall), .eoc_i(eoc_o), .rdata_i(rdata_o), .req_o(host_req),
        .cnt_o(hcnt), .data_o(hdata), .stamp_o(hstamp));

    task automatic results();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        tb_req.wr <= 1'b1;
        tb_req.addr <= a;
        tb_req.wdata <= d;
        @(posedge mclk_i);
        tb_req.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the taking edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        tb_req.rd <= 1'b1;
        tb_req.addr <= a;
        @(posedge mclk_i);
        tb_req.rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic f,
                                         input logic [3:0] mx, input logic go);
        ctrl = 32'h0;
        ctrl[sdas_pkg::B_START] = go;
        ctrl[sdas_pkg::B_MODE +: 2] = m;
        ctrl[sdas_pkg::B_FAST] = f;
        ctrl[sdas_pkg::B_MUX +: 4] = mx;
    endfunction : ctrl

    task automatic wait_eoc(input int lim, output int n);
        n = 0;
        while (eoc_o !== 1'b1 && n < lim) begin
            @(posedge mclk_i);
            #1 n++;
        end
        if (eoc_o !== 1'b1) begin
            chk(32'h0, 32'h1, "done wait ran out");
            results();
        end
    endtask : wait_eoc

    task automatic drain(output int n);
        logic [31:0] d;
        n = 0;
        while (eoc_o === 1'b1 && n < 40) begin
            rd(sdas_pkg::A_RES, d);
            n++;
        end
    endtask : drain

    // Host reads a fixed stall after done rises; spacing of reads is spacing of results
    task automatic spacing(input logic [1:0] m, input int lo, input int hi);
        logic [31:0] prev;
        logic [15:0] c;
        int n;
        pat <= 2'h2;
        host_en <= 1'b1;
        wr(sdas_pkg::A_CTRL, ctrl(m, 1'b1, 4'h0, 1'b1));
        for (int k = 0; k < 4; k++) begin
            c = hcnt;
            n = 0;
            // Look after the edge so the host counter has settled
            while (hcnt === c && n < 3000) begin
                tick(1);
                #1 n++;
            end
            if (hcnt === c) begin
                chk(32'h0, 32'h1, "result wait ran out");
                results();
            end
            chk(hdata, 32'h80, "stream value");
            if (k > 0) chk(hstamp - prev >= lo && hstamp - prev <= hi, 1, "spacing");
            prev = hstamp;
        end
        host_en <= 1'b0;
        tick(8);
        wr(sdas_pkg::A_CTRL, 32'h1 << sdas_pkg::B_STOP);
        drain(n);
        $display("spacing test done");
    endtask : spacing

    initial begin : main
        logic [31:0] d;
        int n;
        rows = '{
            '{2'h0, 1'b1, 1'b0, 2'h0, 13'h0000},
            '{2'h0, 1'b1, 1'b1, 2'h1, 13'h00ff},
            '{2'h0, 1'b1, 1'b0, 2'h2, 13'h0080},
            '{2'h1, 1'b1, 1'b0, 2'h2, 13'h0080},
            '{2'h3, 1'b0, 1'b0, 2'h1, 13'h00ff},
            '{2'h2, 1'b1, 1'b0, 2'h1, 13'h00ff},
            '{2'h0, 1'b0, 1'b0, 2'h2, 13'h0800},
            '{2'h0, 1'b0, 1'b1, 2'h1, 13'h0fff}};
        tick(10);
        arst_n_i <= 1'b1;
        tick(1);
        #1 chk(busy_o, 0, "standby");
        chk(eoc_o, 0, "done at reset");
        rd(sdas_pkg::A_STAT, d);
        chk(d, 32'h0, "status reset");
        wr(4'hc, 32'hffffffff);
        rd(4'hc, d);
        chk(d, 32'h0, "unmapped");
        // Table: every mode, both triggers, both resolutions
        foreach (rows[i]) begin
            pat <= rows[i].pat;
            tick(4);
            wr(sdas_pkg::A_CTRL, ctrl(rows[i].mode, rows[i].fast, 4'h0, !rows[i].hw));
            if (rows[i].hw) begin
                soc_i <= 1'b1;
                tick(1);
                soc_i <= 1'b0;
            end
            wait_eoc(20000, n);
            rd(sdas_pkg::A_RES, d);
            chk(d, {19'h0, rows[i].exp}, "result");
            if (rows[i].mode != 2'h0) wr(sdas_pkg::A_CTRL, 32'h1 << sdas_pkg::B_STOP);
            drain(n);
            tick(2);
            chk(busy_o, 0, "idle after run");
            $display("row %0d done", i);
        end
        // Priming latency with an ignored second start mid-run
        pat <= 2'h1;
        wr(sdas_pkg::A_CTRL, ctrl(2'h0, 1'b1, 4'h0, 1'b1));
        tick(200);
        soc_i <= 1'b1;
        tick(1);
        soc_i <= 1'b0;
        wait_eoc(2000, n);
        chk(n + 201 >= 508 && n + 201 <= 540, 1, "single latency");
        tick(100);
        #1 chk(eoc_o, 1, "done held");
        rd(sdas_pkg::A_STAT, d);
        chk(d[sdas_pkg::B_DONE], 1, "status done");
        chk(d[sdas_pkg::B_LVL +: 6], 1, "one result");
        chk(d[sdas_pkg::B_PRIMED], 1, "primed flag");
        chk(d[sdas_pkg::B_BUSY], 1, "busy until read");
        rd(sdas_pkg::A_RES, d);
        chk(eoc_o, 0, "done cleared by read");
        tick(1);
        #1 chk(busy_o, 0, "back to standby");
        tick(600);
        chk({busy_o, eoc_o}, 0, "stays idle");
        $display("single timing test done");
        // Input change mid-run in single mode, never in continuous
        wr(sdas_pkg::A_CTRL, ctrl(2'h0, 1'b1, 4'h0, 1'b1));
        tick(300);
        wr(sdas_pkg::A_CTRL, ctrl(2'h0, 1'b1, 4'h5, 1'b0));
        #1 chk(mux_sel_o, 4'h5, "input select");
        wait_eoc(2000, n);
        chk(n >= 500, 1, "re-prime after switch");
        drain(n);
        $display("switch test done");
        spacing(2'h2, 120, 136);
        stall <= 8'h14;
        spacing(2'h1, 500, 560);
        // Fill the FIFO with no reader, then drain it
        pat <= 2'h1;
        wr(sdas_pkg::A_CTRL, ctrl(2'h2, 1'b1, 4'h0, 1'b1));
        n = 0;
        d = 32'h0;
        while (d[sdas_pkg::B_FULL] !== 1'b1 && n < 300) begin
            tick(32);
            rd(sdas_pkg::A_STAT, d);
            n++;
        end
        chk(d[sdas_pkg::B_LVL +: 6], 32, "full level");
        wr(sdas_pkg::A_CTRL, 32'h1 << sdas_pkg::B_STOP);
        drain(n);
        chk(n >= 32, 1, "drained count");
        rd(sdas_pkg::A_RES, d);
        chk(eoc_o, 0, "empty read");
        $display("fifo test done");
        tick(2);
        results();
    end

    initial begin
        tick(100000);
        error_cnt++;
        $display("ERROR %0t run limit reached", $time);
        results();
    end
endmodule : sdas_seq_tb_top
